// >>> scrtc_pkg.sv
package scrtc_pkg;

    // ****************************************
    // field positions
    // ****************************************
    localparam int POS_AUTH_INSTR = 17;
    localparam int POS_AUTH_KEY   = 16;
    localparam int POS_ERR_REC    = 15;
    localparam int POS_ORD_REG    = 14;
    localparam int POS_WAIT_EV    = 13;
    localparam int POS_WAIT_IRQ   = 12;
    localparam int POS_SEC_TMR    = 11;
    localparam int POS_RW         = 10;
    localparam int POS_FETCH_GD   = 9;
    localparam int POS_HYP_EN     = 8;
    localparam int POS_MON_DIS    = 7;
    localparam int POS_ABT_RT     = 3;
    localparam int POS_FAST_RT    = 2;
    localparam int POS_IRQ        = 1;
    localparam int POS_NONSEC     = 0;
    localparam int POS_SEC_L2EN   = 18;
    localparam int POS_SEC_EXT    = 62;

    // ****************************************
    // values and masks
    // ****************************************
    localparam logic [63:0] SCR_RESET    = 64'h0000_0000_0000_0030;
    localparam logic [63:0] SCR_RES1     = 64'h0000_0000_0000_0030;
    localparam logic [63:0] SCR_BASE_WR  = 64'h0000_0000_0000_3a8f;
    localparam logic [5:0]  EC_UNDEF     = 6'h00;
    localparam logic [5:0]  EC_WAIT      = 6'h01;
    localparam logic [5:0]  EC_SYS32     = 6'h03;
    localparam logic [5:0]  EC_PAUTH     = 6'h09;
    localparam logic [5:0]  EC_SYS64     = 6'h18;
    localparam logic [1:0]  LVL0         = 2'h0;
    localparam logic [1:0]  LVL1         = 2'h1;
    localparam logic [1:0]  LVL2         = 2'h2;
    localparam logic [1:0]  LVL3         = 2'h3;
    localparam int          SYNC_STAGES  = 3;

    typedef enum logic [3:0] {
        CLS_PAUTH,
        CLS_KEYREG,
        CLS_ERRREG,
        CLS_LORREG,
        CLS_WAIT_EV,
        CLS_WAIT_IRQ,
        CLS_STIMER,
        CLS_HYPCALL,
        CLS_SMC
    } scrtc_cls_e;

endpackage

// >>> scrtc_sync.sv
`timescale 1ns/10ps
module scrtc_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         clk_en,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_q
);
    import scrtc_pkg::*;

    logic [W-1:0] stage_q [SYNC_STAGES];

    // ****************************************
    // three stages, accept when last two agree
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    stage_q[0][i] <= 1'b0;
                    stage_q[1][i] <= 1'b0;
                    stage_q[2][i] <= 1'b0;
                    sync_q[i]     <= 1'b0;
                end
                else if (clk_en)
                begin
                    stage_q[0][i] <= async_in[i];
                    stage_q[1][i] <= stage_q[0][i];
                    stage_q[2][i] <= stage_q[1][i];
                    if (stage_q[1][i] == stage_q[2][i])
                        sync_q[i] <= stage_q[2][i];
                end
            end
        end
    endgenerate

endmodule

// >>> scrtc_top.sv
`timescale 1ns/10ps
// Behaviour
// - bit 17 clear traps auth instructions, class 0x09
// - trap only when key enable set
// - no secure level-2: generic sign trapped too
// - no top level: auth controls act as 1
// - bit 16 clear traps key registers, class 0x18
// - bit 15 traps error records, class 0x18
// - 32-bit error record access uses class 0x03
// - bit 14 traps ordering-region registers
// - bit 13 traps wait-for-event, class 0x01
// - bit 12 traps wait-for-interrupt, class 0x01
// - failing conditional wait never traps
// - wait trap taken when wait would hang
// - bit 11 traps secure level-1 timer access
// - bit 10 execution state, forced one cases
// - no 32-bit support: bit 10 reads one
// - bit 9 blocks nonsecure fetch when secure
// - bit 8 enables hypervisor calls
// - bit 7 disables monitor calls at level1+
// - bits 3..1 route abort, fast, normal irq
// - realm: bit 0 with bit 62 selects state
// - no realm: secure level-2 is 64-bit secure
// - warm reset values are unspecified
module scrtc_top
    import scrtc_pkg::*;
#(
    parameter bit HAS_EL3   = 1'b1,
    parameter bit HAS_EL2   = 1'b1,
    parameter bit HAS_SEL2  = 1'b1,
    parameter bit HAS_PAUTH = 1'b1,
    parameter bit HAS_RAS   = 1'b1,
    parameter bit HAS_RAS11 = 1'b1,
    parameter bit HAS_LOR   = 1'b1,
    parameter bit HAS_WFXT  = 1'b1,
    parameter bit HAS_RME   = 1'b1,
    parameter bit EL1_AA32  = 1'b1,
    parameter bit EL2_AA32  = 1'b0
) (
    input  wire logic              clk,
    input  wire logic              clk_en,
    input  wire logic              sys_rst,
    input  wire logic [1:0]        cur_el,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [63:0]       reg_wdata,
    output logic      [63:0]       reg_rdata_q,
    output logic                   reg_undef_q,
    input  wire logic              chk_valid,
    input  wire scrtc_pkg::scrtc_cls_e chk_class,
    input  wire logic [1:0]        chk_el,
    input  wire logic              chk_aa32,
    input  wire logic              chk_secure,
    input  wire logic              chk_cond_pass,
    input  wire logic              chk_key_en,
    input  wire logic              chk_generic,
    input  wire logic              chk_hyp_trapped,
    input  wire logic              chk_misc_ext,
    input  wire logic              chk_timeout_var,
    input  wire logic              chk_would_block,
    output logic                   chk_done_q,
    output logic                   chk_trap_q,
    output logic                   chk_undef_q,
    output logic      [5:0]        chk_ec_q,
    input  wire logic              abort_pin,
    input  wire logic              fast_irq_pin,
    input  wire logic              irq_pin,
    output logic      [2:0]        route_top_q,
    output logic      [2:0]        route_low_q,
    output logic                   lower_aa64_q,
    output logic      [1:0]        lower_state_q,
    output logic                   fetch_guard_q
);
    import scrtc_pkg::*;

    // ****************************************
    // register storage and write mask
    // ****************************************
    logic [63:0] scr_q;
    logic [63:0] scr_d;
    logic [63:0] wr_mask;
    logic        aa32_cap;
    logic        at_top;

    assign aa32_cap = EL1_AA32 | EL2_AA32;
    assign at_top   = (cur_el == LVL3);

    assign wr_mask = SCR_BASE_WR
        | ({63'h0, HAS_PAUTH} << POS_AUTH_INSTR)
        | ({63'h0, HAS_PAUTH} << POS_AUTH_KEY)
        | ({63'h0, HAS_RAS} << POS_ERR_REC)
        | ({63'h0, HAS_LOR} << POS_ORD_REG)
        | ({63'h0, aa32_cap} << POS_RW)
        | ({63'h0, HAS_EL2} << POS_HYP_EN)
        | ({63'h0, HAS_SEL2} << POS_SEC_L2EN)
        | ({63'h0, HAS_RME} << POS_SEC_EXT);

    assign scr_d = (reg_wdata & wr_mask) | SCR_RES1;

    // arbitrary defined value; software must program it
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            scr_q <= SCR_RESET;
        else if (clk_en && reg_wr && at_top)
            scr_q <= scr_d;
    end

    // ****************************************
    // effective field values
    // ****************************************
    logic        auth_instr_eff;
    logic        auth_key_eff;
    logic        err_rec_eff;
    logic        ord_reg_eff;
    logic        wait_ev_eff;
    logic        wait_irq_eff;
    logic        sec_tmr_eff;
    logic        rw_eff;
    logic        fetch_gd_eff;
    logic        hyp_en_eff;
    logic        mon_dis_eff;
    logic        nonsec_eff;
    logic        sec_ext_eff;
    logic        sec_l2en_eff;
    logic        el2_on;
    logic [63:0] scr_view;

    assign auth_instr_eff = !HAS_EL3 | scr_q[POS_AUTH_INSTR];
    assign auth_key_eff   = !HAS_EL3 | scr_q[POS_AUTH_KEY];
    assign err_rec_eff    = HAS_RAS & scr_q[POS_ERR_REC];
    assign ord_reg_eff    = HAS_LOR & scr_q[POS_ORD_REG];
    assign wait_ev_eff    = scr_q[POS_WAIT_EV];
    assign wait_irq_eff   = scr_q[POS_WAIT_IRQ];
    assign sec_tmr_eff    = scr_q[POS_SEC_TMR];
    assign fetch_gd_eff   = scr_q[POS_FETCH_GD];
    assign hyp_en_eff     = HAS_EL2 & scr_q[POS_HYP_EN];
    assign mon_dis_eff    = scr_q[POS_MON_DIS];
    assign nonsec_eff     = scr_q[POS_NONSEC];
    assign sec_ext_eff    = HAS_RME & scr_q[POS_SEC_EXT];
    assign sec_l2en_eff   = HAS_SEL2 & scr_q[POS_SEC_L2EN];
    // level 2 enabled in the security state of the instruction
    assign el2_on         = HAS_EL2 & (!chk_secure | sec_l2en_eff);

    assign rw_eff = !aa32_cap
        | scr_q[POS_RW]
        | (EL1_AA32 & nonsec_eff & !EL2_AA32)
        | (sec_l2en_eff & !nonsec_eff);

    // stored value with read-as-one fill when no 32-bit state
    assign scr_view = scr_q | ({63'h0, !aa32_cap} << POS_RW);

    // ****************************************
    // register read port
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata_q <= 64'h0;
            reg_undef_q <= 1'b0;
        end
        else if (clk_en)
        begin
            reg_undef_q <= (reg_rd | reg_wr) & !at_top;
            if (reg_rd && at_top)
                reg_rdata_q <= scr_view;
        end
    end

    // ****************************************
    // trap decision
    // ****************************************
    function automatic logic mid_el(input logic [1:0] el);
        mid_el = (el == LVL1) || (el == LVL2);
    endfunction

    logic       below_top;
    logic       pa_trap;
    logic       key_trap;
    logic       err_trap;
    logic       lor_trap;
    logic       wait_ok;
    logic       wait_ev_trap;
    logic       wait_irq_trap;
    logic       tmr_trap;
    logic       tmr_undef;
    logic       hyp_undef;
    logic       smc_undef;
    logic       trap_d;
    logic       undef_d;
    logic [5:0] ec_d;

    assign below_top = (chk_el != LVL3);

    assign pa_trap = HAS_PAUTH & !auth_instr_eff & below_top
        & chk_key_en
        & (!chk_generic | !HAS_SEL2);

    assign key_trap = HAS_PAUTH & !auth_key_eff & mid_el(chk_el)
        & !chk_hyp_trapped;

    assign err_trap = err_rec_eff & mid_el(chk_el)
        & (!chk_misc_ext | HAS_RAS11);

    assign lor_trap = ord_reg_eff & mid_el(chk_el)
        & !chk_hyp_trapped;

    // a wait that completes by itself is not trapped
    assign wait_ok = below_top
        & (!chk_aa32 | chk_cond_pass)
        & chk_would_block
        & (!chk_timeout_var | HAS_WFXT);

    assign wait_ev_trap  = wait_ev_eff & wait_ok;
    assign wait_irq_trap = wait_irq_eff & wait_ok;

    assign tmr_trap = sec_tmr_eff & (chk_el == LVL1) & chk_secure
        & !chk_aa32;
    assign tmr_undef = (chk_el == LVL0);

    assign hyp_undef = (chk_el == LVL0)
        | ((chk_el == LVL1) & chk_secure & !sec_l2en_eff)
        | !hyp_en_eff
        | (mid_el(chk_el) & !el2_on);

    assign smc_undef = (chk_el == LVL0)
        | (mon_dis_eff & !((chk_el == LVL1) & chk_hyp_trapped));

    always_comb
    begin
        trap_d  = 1'b0;
        undef_d = 1'b0;
        ec_d    = EC_UNDEF;
        unique case (chk_class)
            CLS_PAUTH:
            begin
                trap_d = pa_trap;
                ec_d   = EC_PAUTH;
            end
            CLS_KEYREG:
            begin
                trap_d = key_trap;
                ec_d   = EC_SYS64;
            end
            CLS_ERRREG:
            begin
                trap_d = err_trap;
                ec_d   = chk_aa32 ? EC_SYS32 : EC_SYS64;
            end
            CLS_LORREG:
            begin
                trap_d = lor_trap;
                ec_d   = EC_SYS64;
            end
            CLS_WAIT_EV:
            begin
                trap_d = wait_ev_trap;
                ec_d   = EC_WAIT;
            end
            CLS_WAIT_IRQ:
            begin
                trap_d = wait_irq_trap;
                ec_d   = EC_WAIT;
            end
            CLS_STIMER:
            begin
                trap_d  = tmr_trap & !tmr_undef;
                undef_d = tmr_undef;
                ec_d    = tmr_undef ? EC_UNDEF : EC_SYS64;
            end
            CLS_HYPCALL:
            begin
                undef_d = hyp_undef;
                ec_d    = EC_UNDEF;
            end
            CLS_SMC:
            begin
                undef_d = smc_undef;
                ec_d    = EC_UNDEF;
            end
            default:
            begin
                trap_d  = 1'b0;
                undef_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            chk_done_q  <= 1'b0;
            chk_trap_q  <= 1'b0;
            chk_undef_q <= 1'b0;
            chk_ec_q    <= EC_UNDEF;
        end
        else if (clk_en)
        begin
            chk_done_q  <= chk_valid;
            chk_trap_q  <= chk_valid & trap_d;
            chk_undef_q <= chk_valid & undef_d;
            chk_ec_q    <= chk_valid ? ec_d : EC_UNDEF;
        end
    end

    // ****************************************
    // asynchronous exception routing
    // ****************************************
    logic [2:0] pin_sync;
    logic [2:0] route_sel;

    scrtc_sync #(
        .W (3)
    ) u_sync (
        .clk      (clk),
        .clk_en   (clk_en),
        .sys_rst  (sys_rst),
        .async_in ({abort_pin, fast_irq_pin, irq_pin}),
        .sync_q   (pin_sync)
    );

    assign route_sel = {scr_q[POS_ABT_RT], scr_q[POS_FAST_RT], scr_q[POS_IRQ]};

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            route_top_q <= 3'h0;
            route_low_q <= 3'h0;
        end
        else if (clk_en)
        begin
            route_top_q <= pin_sync & route_sel;
            route_low_q <= pin_sync & ~route_sel;
        end
    end

    // ****************************************
    // lower level state outputs
    // ****************************************
    logic [1:0] state_d;

    // 0 secure, 1 nonsecure, 2 reserved, 3 realm
    assign state_d = HAS_RME ? {sec_ext_eff, nonsec_eff}
                             : {1'b0, nonsec_eff};

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lower_aa64_q  <= 1'b0;
            lower_state_q <= 2'h0;
            fetch_guard_q <= 1'b0;
        end
        else if (clk_en)
        begin
            lower_aa64_q  <= rw_eff;
            lower_state_q <= state_d;
            fetch_guard_q <= fetch_gd_eff & chk_secure;
        end
    end

endmodule

// >>> scrtc_monitor.sv
`timescale 1ns/10ps
module scrtc_monitor
    import scrtc_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   clk_en,
    input wire logic                   sys_rst,
    input wire logic [1:0]             cur_el,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [63:0]            reg_wdata,
    input wire logic [63:0]            reg_rdata_q,
    input wire logic                   reg_undef_q,
    input wire logic                   chk_valid,
    input wire scrtc_pkg::scrtc_cls_e  chk_class,
    input wire logic [1:0]             chk_el,
    input wire logic                   chk_aa32,
    input wire logic                   chk_secure,
    input wire logic                   chk_cond_pass,
    input wire logic                   chk_would_block,
    input wire logic                   chk_done_q,
    input wire logic                   chk_trap_q,
    input wire logic                   chk_undef_q,
    input wire logic [5:0]             chk_ec_q,
    input wire logic                   fetch_guard_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst || !clk_en);

    // ****************************************
    // helpers
    // ****************************************
    wire       is_wait = chk_valid && (chk_class == CLS_WAIT_EV
                                       || chk_class == CLS_WAIT_IRQ);
    wire       low_acc = (reg_rd || reg_wr) && cur_el != LVL3;
    wire [10:0] wfield = reg_wdata[17:7];
    sequence s_wr3;
        reg_wr && cur_el == LVL3;
    endsequence
    sequence s_rd3;
        reg_rd && cur_el == LVL3;
    endsequence

    // ****************************************
    // properties
    // ****************************************
    chk_answer_next: assert property (chk_valid |=> chk_done_q)
        else $error("no answer one cycle after a check request");
    chk_no_spurious: assert property (!chk_valid |=>
        !chk_done_q && !chk_trap_q && !chk_undef_q && chk_ec_q == 6'h00)
        else $error("answer without a request");
    chk_low_refused: assert property (low_acc |=> reg_undef_q)
        else $error("low level register access not undefined");
    chk_rd_stable: assert property (!(reg_rd && cur_el == LVL3)
        |=> $stable(reg_rdata_q))
        else $error("read data moved without a read");
    chk_wr_rd_back: assert property (s_wr3 ##2 s_rd3
        |=> reg_rdata_q[17:7] == $past(wfield, 3))
        else $error("control fields not read back");
    chk_cond_fail: assert property (is_wait && chk_aa32
        && !chk_cond_pass |=> !chk_trap_q)
        else $error("failing conditional wait trapped");
    chk_wait_class: assert property (is_wait ##1 chk_trap_q
        |-> chk_ec_q == EC_WAIT)
        else $error("wait trap with wrong class");
    chk_hypcall_el0: assert property (chk_valid
        && chk_class == CLS_HYPCALL && chk_el == LVL0
        |=> chk_undef_q && chk_ec_q == EC_UNDEF)
        else $error("level 0 hypervisor call not undefined");
    chk_smc_el0: assert property (chk_valid && chk_class == CLS_SMC
        && chk_el == LVL0 |=> chk_undef_q && !chk_trap_q)
        else $error("level 0 monitor call not undefined");
    chk_timer_el0: assert property (chk_valid
        && chk_class == CLS_STIMER && chk_el == LVL0 |=> chk_undef_q)
        else $error("level 0 timer access not undefined");
    chk_fetch_sec: assert property (fetch_guard_q |-> $past(chk_secure))
        else $error("fetch guard outside secure state");
endmodule

bind scrtc_top scrtc_monitor mon_u (
    .clk, .clk_en, .sys_rst, .cur_el, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_q, .reg_undef_q, .chk_valid, .chk_class, .chk_el, .chk_aa32,
    .chk_secure, .chk_cond_pass, .chk_would_block, .chk_done_q, .chk_trap_q,
    .chk_undef_q, .chk_ec_q, .fetch_guard_q
);

// >>> scrtc_pipe_model.sv
`timescale 1ns/10ps
module scrtc_pipe_model
    import scrtc_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       chk_done_q,
    input wire logic       chk_trap_q,
    input wire logic       chk_undef_q,
    input wire logic [5:0] chk_ec_q,
    output logic     [7:0] taken_q,
    output int             n_taken
);
    // ****************************************
    // pipeline takes each answer as it stands
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            taken_q <= 8'h00;
            n_taken <= 0;
        end
        else if (chk_done_q)
        begin
            taken_q <= {chk_trap_q, chk_undef_q, chk_ec_q};
            n_taken <= n_taken + 1;
        end
    end
endmodule

// >>> secure_monitor_trap_control_bench.sv
`timescale 1ns/10ps
module secure_monitor_trap_control_bench;
    import scrtc_pkg::*;
    localparam logic [63:0] WMASK = 64'h4000_0000_0007_ff8f;
    logic        clk = 1'b0;
    logic        clk_en = 1'b1;
    logic        sys_rst = 1'b1;
    logic [1:0]  cur_el = 2'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        chk_valid = 1'b0;
    logic [63:0] reg_wdata = 64'h0;
    logic [1:0]  chk_el = 2'h0;
    logic [8:0]  f = 9'h0;
    logic [2:0]  pins = 3'h0;
    scrtc_cls_e  chk_class = CLS_PAUTH;
    logic [63:0] reg_rdata_q, m = 64'h0, rd_last = 64'h0, d;
    logic        reg_undef_q, chk_done_q, chk_trap_q, chk_undef_q;
    logic        lower_aa64_q, fetch_guard_q;
    logic [5:0]  chk_ec_q;
    logic [2:0]  route_top_q, route_low_q, rt;
    logic [1:0]  lower_state_q;
    logic [7:0]  taken_q, e_last = 8'h00;
    logic [31:0] r1, r2;
    int          n_taken, num_errors = 0, check_count = 0, n_chk = 0;
    integer      seed = 28469;

    scrtc_top dut_u (
        .clk, .clk_en, .sys_rst, .cur_el, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata_q, .reg_undef_q, .chk_valid, .chk_class, .chk_el,
        .chk_aa32(f[0]), .chk_secure(f[1]), .chk_cond_pass(f[2]),
        .chk_key_en(f[3]), .chk_generic(f[4]), .chk_hyp_trapped(f[5]),
        .chk_misc_ext(f[6]), .chk_timeout_var(f[7]),
        .chk_would_block(f[8]), .chk_done_q, .chk_trap_q, .chk_undef_q,
        .chk_ec_q, .abort_pin(pins[2]), .fast_irq_pin(pins[1]),
        .irq_pin(pins[0]), .route_top_q, .route_low_q, .lower_aa64_q,
        .lower_state_q, .fetch_guard_q
    );
    scrtc_pipe_model pipe_u (
        .clk, .sys_rst, .chk_done_q, .chk_trap_q, .chk_undef_q, .chk_ec_q,
        .taken_q, .n_taken
    );

    initial
    begin
        forever #10 clk = ~clk;
    end

    // ****************************************
    // reference model: {trap, undef, class}
    // ****************************************
    function automatic logic [7:0] model(scrtc_cls_e c, logic [1:0] el,
                                         logic [8:0] v);
        logic mid;
        logic wt;
        mid = el == LVL1 || el == LVL2;
        wt = el != LVL3 && v[8] && (!v[0] || v[2]);
        case (c)
            CLS_PAUTH: return {el != LVL3 && !m[17] && v[3] && !v[4],
                               1'b0, EC_PAUTH};
            CLS_KEYREG: return {mid && !m[16] && !v[5], 1'b0, EC_SYS64};
            CLS_ERRREG: return {mid && m[15], 1'b0,
                                v[0] ? EC_SYS32 : EC_SYS64};
            CLS_LORREG: return {mid && m[14] && !v[5], 1'b0, EC_SYS64};
            CLS_WAIT_EV: return {wt && m[13], 1'b0, EC_WAIT};
            CLS_WAIT_IRQ: return {wt && m[12], 1'b0, EC_WAIT};
            CLS_STIMER: return {el == LVL1 && v[1] && !v[0] && m[11],
                                el == LVL0, el == LVL0 ? EC_UNDEF : EC_SYS64};
            CLS_HYPCALL: return {1'b0, el == LVL0 || !m[8]
                             || (el != LVL3 && v[1] && !m[18]), EC_UNDEF};
            CLS_SMC: return {1'b0, el == LVL0
                             || (m[7] && !(el == LVL1 && v[5])), EC_UNDEF};
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                         input string what);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask

    task automatic reg_op(input logic w, input logic [1:0] el,
                          input logic [63:0] v);
        @(posedge clk);
        cur_el <= el;
        reg_wr <= w;
        reg_rd <= !w;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        if (w && el == LVL3 && clk_en)
            m = (v & WMASK) | 64'h30;
        if (!w && el == LVL3 && clk_en)
            rd_last = m;
        check(reg_undef_q, el != LVL3, "undefined access");
        check(reg_rdata_q, rd_last, "read data");
    endtask

    task automatic chk_op(input scrtc_cls_e c, input logic [1:0] el,
                          input logic [8:0] v);
        logic [7:0] e;
        @(posedge clk);
        chk_valid <= 1'b1;
        chk_class <= c;
        chk_el <= el;
        f <= v;
        @(posedge clk);
        chk_valid <= 1'b0;
        #1;
        e = model(c, el, v);
        e_last = e;
        n_chk++;
        check(chk_done_q, 1'b1, "no answer");
        check({chk_trap_q, chk_undef_q}, e[7:6], "decision");
        if (e[7] | e[6])
            check(chk_ec_q, e[5:0], "class");
    endtask

    task automatic statics;
        repeat (5) @(posedge clk);
        #1;
        rt = {m[3], m[2], m[1]};
        check(fetch_guard_q, m[9] & f[1], "fetch guard");
        check(lower_state_q, {m[62], m[0]}, "state");
        check(lower_aa64_q, m[10] | m[0] | m[18], "exec state");
        check(route_top_q, pins & rt, "route top");
        check(route_low_q, pins & ~rt, "route low");
        check(taken_q[7:6], e_last[7:6], "answer taken");
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        num_errors++;
        complete_run;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        reg_op(1'b0, LVL1, 64'h0);
        for (int i = 0; i < 40; i++)
        begin
            d = {$random(seed), $random(seed)};
            if (i < 2)
                d = i ? '1 : '0;
            reg_op(1'b1, LVL3, d);
            reg_op(1'b0, LVL3, 64'h0);
            reg_op(1'b1, 2'(i % 3), ~d);
            reg_op(1'b0, LVL3, 64'h0);
            // frozen clock enable: write must not land
            @(posedge clk);
            clk_en <= 1'b0;
            reg_op(1'b1, LVL3, ~d);
            reg_op(1'b0, LVL3, 64'h0);
            @(posedge clk);
            r1 = $random(seed);
            pins <= r1[2:0];
            clk_en <= 1'b1;
            for (int c = 0; c < 9; c++)
            begin
                r1 = $random(seed);
                r2 = $random(seed);
                chk_op(scrtc_cls_e'(c), r1[1:0], r2[8:0]);
            end
            statics;
        end
        repeat (2) @(posedge clk);
        check(n_taken, n_chk, "answers taken");
        complete_run;
    end
endmodule
